// *** core/aafs_cfg.svh ***
// register offsets, reset values and timing counts of the activity/filter/sync config slice
// assumes inclusion by core/aafs_core.sv only
`ifndef AAFS_CFG_SVH
`define AAFS_CFG_SVH
// register indexes; byte address is four times the index
`define AAFS_IDX_AXIS_EN   8'h24
`define AAFS_IDX_THR_HIGH  8'h25
`define AAFS_IDX_THR_LOW   8'h26
`define AAFS_IDX_CNT_TGT   8'h27
`define AAFS_IDX_FILTER    8'h28
`define AAFS_IDX_WMARK     8'h29
`define AAFS_IDX_PIN_MAP   8'h2A
`define AAFS_IDX_SYNC      8'h2B
`define AAFS_IDX_POLARITY  8'h2C
// reset values
`define AAFS_RST_AXIS_EN   8'h00
`define AAFS_RST_THR       8'h00
`define AAFS_RST_CNT_TGT   8'h01
`define AAFS_RST_FILTER    8'h00
`define AAFS_RST_WMARK     7'h60
`define AAFS_RST_PIN_MAP   8'h00
`define AAFS_RST_SYNC      3'h0
// field positions
`define AAFS_HPF_MSB       6
`define AAFS_HPF_LSB       4
`define AAFS_ODR_MSB       3
`define AAFS_ODR_LSB       0
`define AAFS_EXTERNAL_CLOCK_SELECT_BIT   2
`define AAFS_POL_BIT       6
// sample bits compared against the threshold
`define AAFS_MAG_MSB       18
`define AAFS_MAG_LSB       3
// interpolated sync delay in oscillator cycles, and highest defined rate code
`define AAFS_ISYNC_MIN     14
`define AAFS_ISYNC_MAX     8204
`define AAFS_ODR_MAX_CODE  4'hA
`endif

// *** core/aafs_pkg.sv ***
// types of the activity/filter/sync config slice
// assumes nothing beyond a SystemVerilog compiler
package aafs_pkg;
  typedef enum logic [1:0] {
    AAFS_SYNC_INT,
    AAFS_SYNC_DIRECT,
    AAFS_SYNC_INTERP,
    AAFS_SYNC_RSVD
  } aafs_sync_mode_t;
  typedef enum logic {AAFS_DLY_IDLE, AAFS_DLY_RUN} aafs_dly_state_t;
endpackage

// *** core/aafs_core.sv ***
// activity detection, filter settings, watermark, irq routing and sync control registers
// assumes an AHB-Lite master on core_clk_i; sync_i and fifo/sample inputs from the core datapath
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "aafs_cfg.svh"
module aafs_core #(
  parameter int unsigned ISYNC_MAX = `AAFS_ISYNC_MAX
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   hsel_i,
  input  wire logic [11:0]            haddr_i,
  input  wire logic [1:0]             htrans_i,
  input  wire logic                   hwrite_i,
  input  wire logic [2:0]             hsize_i,
  input  wire logic [31:0]            hwdata_i,
  input  wire logic                   hready_i,
  output logic      [31:0]            hrdata_o,
  output logic                        hreadyout_o,
  output logic                        hresp_o,
  input  wire logic                   sample_valid_i,
  input  wire logic [19:0]            x_sample_i,
  input  wire logic [19:0]            y_sample_i,
  input  wire logic [19:0]            z_sample_i,
  input  wire logic                   data_ready_i,
  input  wire logic [6:0]             fifo_level_i,
  input  wire logic                   queue_overrun_i,
  input  wire logic                   sync_i,
  output logic                        irq_pin_a_o,
  output logic                        irq_pin_b_o,
  output logic                        sample_ready_o,
  output logic                        activity_o,
  output logic                        hpf_bypass_o,
  output logic      [17:0]            hpf_fraction_o,
  output logic      [3:0]             rate_shift_o,
  output logic      [4:0]             lowpass_shift_o,
  output logic                        external_clock_select_o,
  output aafs_pkg::aafs_sync_mode_t   external_sync_mode_o,
  output logic                        interp_shift_o
);
  import aafs_pkg::*;

  localparam int unsigned ISYNC_STEP = (ISYNC_MAX - `AAFS_ISYNC_MIN) / 10;

  logic [7:0]  axis_en_q;
  logic [15:0] thr_q;
  logic [7:0]  cnt_tgt_q;
  logic [7:0]  filter_q;
  logic [6:0]  wmark_q;
  logic [7:0]  pin_map_q;
  logic [2:0]  sync_q;
  logic        pol_q;
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic [7:0]  run_cnt_q;
  logic        activity_q;
  logic        wm_evt_q;
  logic        sync_m_q;
  logic        sync_s_q;
  logic        sync_p_q;
  logic [13:0] dly_cnt_q;
  aafs_dly_state_t dly_st_q;
  logic        ready_q;
  logic [31:0] rdata_q;
  logic [3:0]  events;
  logic        any_a;
  logic        any_b;
  logic        sync_edge;
  logic [13:0] isync_dly;
  logic [19:0] abs_x;
  logic [19:0] abs_y;
  logic [19:0] abs_z;
  logic [2:0]  over;
  logic        exceed;
  logic [7:0]  idx;
  logic        acc;
  logic [7:0]  rd_val;

  // bus decode; zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign idx         = haddr_i[9:2];
  assign acc         = hsel_i & hready_i & htrans_i[1] & (haddr_i[11:10] == 2'b00);

  // read mux; reserved bits and unmapped indexes read zero
  always_comb begin
    rd_val = 8'h00;
    if (idx == `AAFS_IDX_AXIS_EN) begin
      rd_val = {5'h00, axis_en_q[2:0]};
    end else if (idx == `AAFS_IDX_THR_HIGH) begin
      rd_val = thr_q[15:8];
    end else if (idx == `AAFS_IDX_THR_LOW) begin
      rd_val = thr_q[7:0];
    end else if (idx == `AAFS_IDX_CNT_TGT) begin
      rd_val = cnt_tgt_q;
    end else if (idx == `AAFS_IDX_FILTER) begin
      rd_val = {1'b0, filter_q[6:0]};
    end else if (idx == `AAFS_IDX_WMARK) begin
      rd_val = {1'b0, wmark_q};
    end else if (idx == `AAFS_IDX_PIN_MAP) begin
      rd_val = pin_map_q;
    end else if (idx == `AAFS_IDX_SYNC) begin
      rd_val = {5'h00, sync_q};
    end else if (idx == `AAFS_IDX_POLARITY) begin
      rd_val = {1'b0, pol_q, 6'h00};
    end
  end

  // address phase capture and read data register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= acc & hwrite_i;
      wr_idx_q  <= idx;
      if (acc & !hwrite_i) begin
        rdata_q <= {24'h00_0000, rd_val};
      end
    end
  end
  assign hrdata_o = rdata_q;

  // register writes in the data phase; reserved bits dropped
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      axis_en_q <= `AAFS_RST_AXIS_EN;
      thr_q     <= {`AAFS_RST_THR, `AAFS_RST_THR};
      cnt_tgt_q <= `AAFS_RST_CNT_TGT;
      filter_q  <= `AAFS_RST_FILTER;
      wmark_q   <= `AAFS_RST_WMARK;
      pin_map_q <= `AAFS_RST_PIN_MAP;
      sync_q    <= `AAFS_RST_SYNC;
      pol_q     <= 1'b0;
    end else if (wr_pend_q) begin
      if (wr_idx_q == `AAFS_IDX_AXIS_EN) begin
        axis_en_q <= {5'h00, hwdata_i[2:0]};
      end else if (wr_idx_q == `AAFS_IDX_THR_HIGH) begin
        thr_q[15:8] <= hwdata_i[7:0];
      end else if (wr_idx_q == `AAFS_IDX_THR_LOW) begin
        thr_q[7:0] <= hwdata_i[7:0];
      end else if (wr_idx_q == `AAFS_IDX_CNT_TGT) begin
        cnt_tgt_q <= hwdata_i[7:0];
      end else if (wr_idx_q == `AAFS_IDX_FILTER) begin
        filter_q <= {1'b0, hwdata_i[6:0]};
      end else if (wr_idx_q == `AAFS_IDX_WMARK) begin
        wmark_q <= hwdata_i[6:0];
      end else if (wr_idx_q == `AAFS_IDX_PIN_MAP) begin
        pin_map_q <= hwdata_i[7:0];
      end else if (wr_idx_q == `AAFS_IDX_SYNC) begin
        sync_q <= hwdata_i[2:0];
      end else if (wr_idx_q == `AAFS_IDX_POLARITY) begin
        pol_q <= hwdata_i[`AAFS_POL_BIT];
      end
    end
  end

  // axis magnitudes; bit 19 of the magnitude means above any threshold
  assign abs_x = x_sample_i[19] ? 20'(-x_sample_i) : x_sample_i;
  assign abs_y = y_sample_i[19] ? 20'(-y_sample_i) : y_sample_i;
  assign abs_z = z_sample_i[19] ? 20'(-z_sample_i) : z_sample_i;
  // strict compare on magnitude bits 18:3, gated per axis
  assign over[0] = axis_en_q[0] & (abs_x[19] | (abs_x[18:3] > thr_q));
  assign over[1] = axis_en_q[1] & (abs_y[19] | (abs_y[18:3] > thr_q));
  assign over[2] = axis_en_q[2] & (abs_z[19] | (abs_z[18:3] > thr_q));
  assign exceed  = |over;

  // consecutive-exceedance run counter and activity level
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_cnt_q  <= 8'h00;
      activity_q <= 1'b0;
    end else if (sample_valid_i) begin
      if (!exceed) begin
        run_cnt_q  <= 8'h00;
        activity_q <= 1'b0;
      end else begin
        if (run_cnt_q != 8'hFF) begin
          run_cnt_q <= run_cnt_q + 8'h01;
        end
        activity_q <= ({1'b0, run_cnt_q} + 9'h001) >= {1'b0, cnt_tgt_q};
      end
    end
  end
  assign activity_o = activity_q;

  // watermark reached once stored samples reach the count
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wm_evt_q <= 1'b0;
    end else begin
      wm_evt_q <= fifo_level_i >= wmark_q;
    end
  end

  // filter decode; the host may retune the high-pass while measuring
  assign hpf_bypass_o = filter_q[`AAFS_HPF_MSB:`AAFS_HPF_LSB] == 3'h0;
  always_comb begin
    case (filter_q[`AAFS_HPF_MSB:`AAFS_HPF_LSB]) // units of 1e-8 of the rate
      3'h1:    hpf_fraction_o = 18'd247000;
      3'h2:    hpf_fraction_o = 18'd62084;
      3'h3:    hpf_fraction_o = 18'd15545;
      3'h4:    hpf_fraction_o = 18'd3862;
      3'h5:    hpf_fraction_o = 18'd954;
      3'h6:    hpf_fraction_o = 18'd238;
      default: hpf_fraction_o = 18'd0;
    endcase
  end
  // rate is 4000 Hz shifted right by the code low-pass two more
  assign rate_shift_o    = filter_q[`AAFS_ODR_MSB:`AAFS_ODR_LSB];
  assign lowpass_shift_o = {1'b0, rate_shift_o} + 5'h02;

  // clock source and sync mode out to the timing logic
  assign external_clock_select_o = sync_q[`AAFS_EXTERNAL_CLOCK_SELECT_BIT];
  assign external_sync_mode_o    = aafs_sync_mode_t'(sync_q[1:0]);
  assign interp_shift_o          = external_sync_mode_o == AAFS_SYNC_INTERP;

  // sync pin synchroniser and rising-edge detect
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_m_q <= 1'b0;
      sync_s_q <= 1'b0;
      sync_p_q <= 1'b0;
    end else begin
      sync_m_q <= sync_i;
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q;
    end
  end
  assign sync_edge = sync_s_q & !sync_p_q;
  // delay grows linearly with the rate code, 14 at code 0
  assign isync_dly = 14'(`AAFS_ISYNC_MIN + ISYNC_STEP * rate_shift_o);

  // interpolated sync delay counter
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dly_st_q  <= AAFS_DLY_IDLE;
      dly_cnt_q <= 14'h0000;
    end else begin
      case (dly_st_q)
        AAFS_DLY_IDLE: begin
          if (sync_edge && external_sync_mode_o == AAFS_SYNC_INTERP) begin
            dly_st_q  <= AAFS_DLY_RUN;
            dly_cnt_q <= isync_dly - 14'h0002; // pulse lands on the delay-th cycle
          end
        end
        default: begin
          dly_cnt_q <= dly_cnt_q - 14'h0001;
          if (dly_cnt_q == 14'h0000 || external_sync_mode_o != AAFS_SYNC_INTERP) begin
            dly_st_q <= AAFS_DLY_IDLE;
          end
        end
      endcase
    end
  end

  // sample ready source per sync mode; reserved mode gives none
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_q <= 1'b0;
    end else begin
      case (external_sync_mode_o)
        AAFS_SYNC_INT:    ready_q <= data_ready_i;
        AAFS_SYNC_DIRECT: ready_q <= sync_edge;
        AAFS_SYNC_INTERP: ready_q <= (dly_st_q == AAFS_DLY_RUN) && (dly_cnt_q == 14'h0000);
        default:          ready_q <= 1'b0;
      endcase
    end
  end
  assign sample_ready_o = ready_q;

  // event vector: ready, watermark, overrun, activity
  assign events = {activity_q, queue_overrun_i, wm_evt_q, ready_q};
  assign any_a  = |(events & pin_map_q[3:0]);
  assign any_b  = |(events & pin_map_q[7:4]);

  // pin drivers with polarity
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_pin_a_o <= 1'b1;
      irq_pin_b_o <= 1'b1;
    end else begin
      irq_pin_a_o <= pol_q ? any_a : !any_a;
      irq_pin_b_o <= pol_q ? any_b : !any_b;
    end
  end

  // checks
  property p_wmark;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (fifo_level_i >= wmark_q) |=> wm_evt_q;
  endproperty
  a_wmark: assert property (p_wmark) else $error("watermark not raised");

  property p_pin_a;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (|(events & pin_map_q[3:0])) |=> (irq_pin_a_o == $past(pol_q));
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a not asserted");

  property p_pin_b;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (|(events & pin_map_q[7:4])) |=> (irq_pin_b_o == $past(pol_q));
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b not asserted");

  property p_idle_pol;
    @(posedge core_clk_i) disable iff (!rstn_i)
      !(|(events & pin_map_q[7:4])) |=> (irq_pin_b_o != $past(pol_q));
  endproperty
  a_idle_pol: assert property (p_idle_pol) else $error("pin b idle level wrong");

  property p_run_clear;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (sample_valid_i && !exceed) |=> (run_cnt_q == 8'h00) && !activity_q;
  endproperty
  a_run_clear: assert property (p_run_clear) else $error("run not cleared");

  property p_activity;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (sample_valid_i && exceed && ({1'b0, run_cnt_q} + 9'h001 >= {1'b0, cnt_tgt_q}))
        |=> activity_q;
  endproperty
  a_activity: assert property (p_activity) else $error("activity not declared");

  property p_direct;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (sync_edge && external_sync_mode_o == AAFS_SYNC_DIRECT) |=> sample_ready_o;
  endproperty
  a_direct: assert property (p_direct) else $error("no ready on sync");

  property p_interp;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (sync_edge && external_sync_mode_o == AAFS_SYNC_INTERP && dly_st_q == AAFS_DLY_IDLE
        && rate_shift_o == 4'h0)
        |-> ##14 (sample_ready_o || (external_sync_mode_o != AAFS_SYNC_INTERP));
  endproperty
  a_interp: assert property (p_interp) else $error("interpolated ready late");

  property p_bypass;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (filter_q[6:4] == 3'h0) |-> (hpf_bypass_o && (hpf_fraction_o == 18'd0));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass decode wrong");
endmodule

// *** tb/aafs_host.sv ***
// host model: AHB-Lite master issuing single whole-word transfers to the config slice
// assumes one slave whose hreadyout is looped back as the bus hready
`timescale 1ns/1ps
module aafs_host (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [11:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  // bus idle at time zero, word transfers only
  initial begin
    hsel_o = 1'b0;
    haddr_o = 12'h000;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0000_0000;
  end

  // one transfer: address phase held until hready, then data phase held until hready
  // configuration is only written while the datapath idles between the steps of a scenario
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {2'b00, idx, 2'b00};
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= {24'h00_0000, wd};
    do @(posedge clk_i); while (hready_i !== 1'b1);
    rd = hrdata_i;
  endtask
endmodule

// *** tb/tb_aafs_core.sv ***
// self-checking bench: registers, filter decode, irq routing, activity and sync timing
// assumes the host model drives the register bus; the bench drives the datapath inputs
`timescale 1ns/1ps
module tb_aafs_core;
  import aafs_pkg::*;
  localparam int unsigned ISYNC_MAX = 124; // shortened: 11 cycles per rate code
  logic            core_clk_i;
  logic            rstn_i;
  logic            hsel, hwrite, hreadyout, hresp, sample_valid, data_ready, overrun, sync;
  logic [11:0]     haddr;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     hwdata, hrdata, rd;
  logic [19:0]     xs, ys, zs;
  logic [6:0]      fifo_level;
  logic            pin_a, pin_b, ready, act, bypass, external_clock_select, interp, seen_a, seen_b;
  logic [17:0]     fraction;
  logic [3:0]      rate_shift;
  logic [4:0]      lp_shift;
  aafs_sync_mode_t sync_mode;
  int              mismatches = 0;
  int              checks = 0;

  aafs_core #(.ISYNC_MAX(ISYNC_MAX)) i_aafs_core (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
    .sample_valid_i(sample_valid), .x_sample_i(xs), .y_sample_i(ys), .z_sample_i(zs),
    .data_ready_i(data_ready), .fifo_level_i(fifo_level), .queue_overrun_i(overrun),
    .sync_i(sync), .irq_pin_a_o(pin_a), .irq_pin_b_o(pin_b), .sample_ready_o(ready),
    .activity_o(act), .hpf_bypass_o(bypass), .hpf_fraction_o(fraction),
    .rate_shift_o(rate_shift), .lowpass_shift_o(lp_shift),
    .external_clock_select_o(external_clock_select), .external_sync_mode_o(sync_mode),
    .interp_shift_o(interp));
  aafs_host i_aafs_host (.clk_i(core_clk_i), .hready_i(hreadyout), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  // 25 ns clock
  initial core_clk_i = 1'b0;
  always #12.5 core_clk_i = ~core_clk_i;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // write, then one edge so the new value is settled
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_aafs_host.xfer(1'b1, idx, d, rd);
    @(posedge core_clk_i);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    i_aafs_host.xfer(1'b0, idx, 8'h00, rd);
    check(what, rd, {24'h00_0000, exp});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one sample set, valid for a single cycle
  task automatic sample(input logic [19:0] x, input logic [19:0] y, input logic [19:0] z);
    @(posedge core_clk_i);
    xs <= x;
    ys <= y;
    zs <= z;
    sample_valid <= 1'b1;
    @(posedge core_clk_i);
    sample_valid <= 1'b0;
    cyc(2);
  endtask

  // raise one event source and note whether either pin showed its asserted level
  task automatic route_one(input int ev, input logic pol);
    seen_a = 1'b0;
    seen_b = 1'b0;
    @(posedge core_clk_i);
    data_ready <= (ev == 0);
    fifo_level <= (ev == 1) ? 7'h60 : 7'h00;
    overrun <= (ev == 2);
    sample_valid <= (ev == 3);
    xs <= 20'h0_0100;
    repeat (6) begin
      @(posedge core_clk_i);
      data_ready <= 1'b0;
      sample_valid <= 1'b0;
      seen_a = seen_a | (pin_a === pol);
      seen_b = seen_b | (pin_b === pol);
    end
    fifo_level <= 7'h00;
    overrun <= 1'b0;
    sample(20'h0_0000, 20'h0_0000, 20'h0_0000);
    cyc(4);
  endtask

  // edges from a sync rise to the ready pulse, 200 meaning none
  task automatic sync_lat(output int n);
    @(posedge core_clk_i);
    sync <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (ready !== 1'b1 && n < 200);
    sync <= 1'b0;
    cyc(20);
  endtask

  task automatic t_regs;
    logic [7:0] idx [10] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h30};
    logic [7:0] msk [10] = '{8'h07, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'hff, 8'h07, 8'h40, 8'h00};
    logic [7:0] rst [10] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00};
    check("reset_outs", {bypass, lp_shift, pin_a, pin_b, hresp}, 9'b1_0001_0110);
    for (int i = 0; i < 10; i++) begin
      rd_chk("reset_val", idx[i], rst[i]);
      wr(idx[i], 8'hff);
      rd_chk("ones_val", idx[i], msk[i]);
      if (idx[i] == 8'h2b) check("external_clock_select", external_clock_select, 1'b1);
      wr(idx[i], rst[i]);
      rd_chk("restore_val", idx[i], rst[i]);
    end
    $display("test registers done");
  endtask

  task automatic t_decode;
    int unsigned frac [7] = '{0, 247000, 62084, 15545, 3862, 954, 238};
    for (int c = 0; c < 7; c++) begin
      wr(8'h28, {1'b0, 3'(c), 4'h0});
      check("bypass", bypass, c == 0);
      check("fraction", fraction, frac[c]);
    end
    for (int c = 0; c <= 10; c++) begin
      wr(8'h28, 8'(c));
      check("rate", rate_shift, c);
      check("lowpass", lp_shift, c + 2);
    end
    $display("test decode done");
  endtask

  task automatic t_route;
    wr(8'h24, 8'h01);
    for (int b = 0; b < 8; b++) begin
      wr(8'h2a, 8'(1 << b));
      route_one(b % 4, 1'b0);
      check("pin_a", seen_a, b < 4);
      check("pin_b", seen_b, b >= 4);
    end
    wr(8'h2c, 8'h40);
    cyc(3);
    check("idle_high_pol", {pin_a, pin_b}, 2'b00);
    wr(8'h2a, 8'h0f);
    route_one(2, 1'b1);
    check("shared_pin", {seen_a, seen_b}, 2'b10);
    wr(8'h29, 8'h05);
    wr(8'h2a, 8'h02);
    fifo_level <= 7'h04;
    cyc(4);
    check("below_wm", pin_a, 1'b0);
    fifo_level <= 7'h05;
    cyc(4);
    check("at_wm", pin_a, 1'b1);
    fifo_level <= 7'h00;
    $display("test routing done");
  endtask

  task automatic t_activity;
    wr(8'h24, 8'h02);
    wr(8'h26, 8'h10);
    wr(8'h27, 8'h03);
    sample(20'h0_0000, 20'h0_0087, 20'h0_0000);
    sample(20'h0_0000, 20'h0_0088, 20'h0_0000);
    sample(20'h0_0000, 20'hf_ff78, 20'h0_0000);
    check("act_two_of_three", act, 1'b0);
    sample(20'h7_ffff, 20'h0_0080, 20'h7_ffff);
    sample(20'h0_0000, 20'h0_0088, 20'h0_0000);
    sample(20'h0_0000, 20'h0_0088, 20'h0_0000);
    check("act_run_broken", act, 1'b0);
    sample(20'h0_0000, 20'h0_0088, 20'h0_0000);
    check("act_declared", act, 1'b1);
    sample(20'h0_0000, 20'h0_0000, 20'h0_0000);
    check("act_cleared", act, 1'b0);
    wr(8'h27, 8'h01);
    wr(8'h25, 8'h01);
    sample(20'h7_ffff, 20'h0_0880, 20'h7_ffff);
    check("act_equal_thr", act, 1'b0);
    sample(20'h0_0000, 20'h0_0888, 20'h0_0000);
    check("act_above_thr", act, 1'b1);
    sample(20'h0_0000, 20'h0_0000, 20'h0_0000);
    $display("test activity done");
  endtask

  task automatic t_sync;
    int n0;
    int n;
    wr(8'h2b, 8'h01);
    check("mode_direct", sync_mode, AAFS_SYNC_DIRECT);
    sync_lat(n0);
    check("direct_ready", n0 < 8, 1'b1);
    for (int c = 0; c <= 10; c += 10) begin
      wr(8'h28, 8'(c));
      wr(8'h2b, 8'h02);
      check("interp", interp, 1'b1);
      sync_lat(n);
      check("interp_delay", n - n0 + 1, 14 + c * (ISYNC_MAX - 14) / 10);
    end
    wr(8'h2b, 8'h00);
    sync_lat(n);
    check("internal_ignores_sync", n, 200);
    wr(8'h2b, 8'h04);
    check("external_clock_select_mode", {external_clock_select, interp, sync_mode}, 4'b1000);
    $display("test sync done");
  endtask

  // main sequence: 12-cycle reset, then the scenarios
  initial begin
    rstn_i = 1'b0;
    sample_valid = 1'b0;
    xs = 20'h0_0000;
    ys = 20'h0_0000;
    zs = 20'h0_0000;
    data_ready = 1'b0;
    fifo_level = 7'h00;
    overrun = 1'b0;
    sync = 1'b0;
    cyc(12);
    rstn_i <= 1'b1;
    t_regs;
    t_decode;
    t_route;
    t_activity;
    t_sync;
    stop_test;
  end

  // watchdog, well beyond the roughly one thousand cycles the scenarios need
  initial begin
    #500000;
    mismatches++;
    stop_test;
  end
endmodule
